// *** rtl/wdr_watchdog.sv ***
// Watchdog reset timer: 8-bit counter on a prescaled system clock,
// guarded control/status register and chip-wide overflow reset.
// Assumes an Avalon-MM master on the same clock and that rst is the
// external reset pin, already synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Counter write enable changes only with inhibit zero
// - Counter writes accepted only while enabled
// - Register write enable changes only with inhibit zero
// - Enable and flag writable only under register enable
// - Inhibit bits read one, never stored
// - Enable set or cleared by guarded write
// - Counter advances only while watchdog enabled
// - Flag cleared by pin reset or guarded zero
// - Overflow reset drives the whole chip
// - Readable 8-bit up-counter, reset to zero
// - Wrap raises internal reset and sets flag
// - Clock select chooses divide 64 to 8192
// - Clock select upper bits read one
// - Internal reset one clock after overflow pulse
// - Internal reset lasts 512 oscillator cycles
// - Written count becomes the new start point
// - Counter, status and select follow power modes
module wdr_watchdog
  import wdr_pkg::*;
#(
  parameter int unsigned RST_CYCLES = WDR_RST_SYS_CYC
)(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire wdr_pmode_t            power_mode,
  input  wire logic [WDR_ADDR_W-1:0] address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [31:0]           writedata,
  input  wire logic [3:0]            byteenable,
  output var  logic [31:0]           readdata,
  output var  logic                  waitrequest,
  output var  logic                  chip_reset_q,
  output var  logic                  wd_enable_q
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  wdr_csr_t   csr_q;
  logic [7:0] count_q;
  logic [2:0] clksel_q;
  logic       wait_q;
  logic [31:0] rdata_q;
  logic       ovf_q;
  logic       int_rst;
  logic       blk_rst;
  logic       tick;
  logic       run_cnt;
  logic       csr_live;
  logic       sel_live;
  logic       acc;
  logic       wr_ok;
  logic       sel_csr;
  logic       sel_cnt;
  logic       sel_clk;
  logic [7:0] wb;
  logic [7:0] csr_rd;
  logic       wrap;

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  // Counter and status run in active and sleep; clock select only
  // accepts writes in active, so it is retained in every other mode
  always_comb
  begin
    run_cnt  = 1'b0;
    csr_live = 1'b0;
    sel_live = 1'b0;
    unique case (power_mode)
      WDR_PM_ACTIVE:
      begin
        run_cnt  = 1'b1;
        csr_live = 1'b1;
        sel_live = 1'b1;
      end
      WDR_PM_SLEEP:
      begin
        run_cnt  = 1'b1;
        csr_live = 1'b1;
      end
      WDR_PM_WATCH,
      WDR_PM_SUBACTIVE,
      WDR_PM_SUBSLEEP,
      WDR_PM_STANDBY:
      begin
        run_cnt  = 1'b0;
      end
      default:
      begin
        run_cnt  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Resets
  // ----------------------------------------------------------------
  // The overflow reset clears the block too, but the flag survives it
  assign int_rst = chip_reset_q;
  assign blk_rst = rst | int_rst;

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  assign acc     = (read | write) & !wait_q;
  assign wr_ok   = write & !wait_q & byteenable[0];
  assign sel_csr = (address == WDR_OFS_CTRL_STAT);
  assign sel_cnt = (address == WDR_OFS_COUNT);
  assign sel_clk = (address == WDR_OFS_CLKSEL);
  assign wb      = writedata[7:0];

  always_ff @(posedge clock)
  begin
    if (rst)
      wait_q <= 1'b1;
    else if ((read | write) && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  // Inhibit bits always read back as one
  always_comb
  begin
    csr_rd                  = 8'h00;
    csr_rd[WDR_CNT_WEN_INH] = 1'b1;
    csr_rd[WDR_REG_WEN_INH] = 1'b1;
    csr_rd[WDR_ON_INH]      = 1'b1;
    csr_rd[WDR_FLAG_INH]    = 1'b1;
    csr_rd[WDR_CNT_WEN]     = csr_q.cnt_write_enable;
    csr_rd[WDR_REG_WEN]     = csr_q.reg_write_enable;
    csr_rd[WDR_ENABLE]      = csr_q.wd_enable;
    csr_rd[WDR_FLAG]        = csr_q.overflow_reset_flag;
  end

  // Read data is captured in the cycle that ends the wait
  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_q <= WDR_RDATA_ZERO;
    else if (read && wait_q)
    begin
      if (sel_csr)
        rdata_q <= {24'h00_0000, csr_rd};
      else if (sel_cnt)
        rdata_q <= {24'h00_0000, count_q};
      else if (sel_clk)
        rdata_q <= {24'h00_0000, WDR_CLKSEL_PAD, clksel_q};
      else
        rdata_q <= WDR_RDATA_ZERO;
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;

  // ----------------------------------------------------------------
  // Control/status: counter write enable
  // ----------------------------------------------------------------
  // Every gate below reads the enables as held before this write
  always_ff @(posedge clock)
  begin
    if (blk_rst)
      csr_q.cnt_write_enable <= 1'b0;
    else if (wr_ok && sel_csr && csr_live
             && !wb[WDR_CNT_WEN_INH])
      csr_q.cnt_write_enable <= wb[WDR_CNT_WEN];
  end

  // ----------------------------------------------------------------
  // Control/status: register write enable
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (blk_rst)
      csr_q.reg_write_enable <= 1'b0;
    else if (wr_ok && sel_csr && csr_live
             && !wb[WDR_REG_WEN_INH])
      csr_q.reg_write_enable <= wb[WDR_REG_WEN];
  end

  // ----------------------------------------------------------------
  // Control/status: watchdog on
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (blk_rst)
      csr_q.wd_enable <= 1'b0;
    else if (wr_ok && sel_csr && csr_live
             && csr_q.reg_write_enable
             && !wb[WDR_ON_INH])
      csr_q.wd_enable <= wb[WDR_ENABLE];
  end

  assign wd_enable_q = csr_q.wd_enable;

  // ----------------------------------------------------------------
  // Control/status: overflow reset flag
  // ----------------------------------------------------------------
  // Of the resets only the pin reset clears it, so software can tell after boot
  // whether the watchdog fired; the hardware set beats a clear
  always_ff @(posedge clock)
  begin
    if (rst)
      csr_q.overflow_reset_flag <= 1'b0;
    else if (ovf_q)
      csr_q.overflow_reset_flag <= 1'b1;
    else if (wr_ok && sel_csr && csr_live
             && csr_q.reg_write_enable
             && !wb[WDR_FLAG_INH]
             && !wb[WDR_FLAG])
      csr_q.overflow_reset_flag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Clock select
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (blk_rst)
      clksel_q <= WDR_CLKSEL_RST;
    else if (wr_ok && sel_clk && sel_live)
      clksel_q <= wb[2:0];
  end

  wdr_prescaler #(
    .TAPS   (8)
  ) u_presc (
    .clock  (clock),
    .rst    (blk_rst),
    .run    (run_cnt),
    .sel    (clksel_q),
    .tick_q (tick)
  );

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A guarded write wins over a coincident tick, and a write that
  // lands on a wrap suppresses that overflow
  assign wrap = tick && csr_q.wd_enable && run_cnt
                && (count_q == WDR_COUNT_MAX);

  always_ff @(posedge clock)
  begin
    if (blk_rst)
      count_q <= WDR_COUNT_RST;
    else if (wr_ok && sel_cnt && csr_q.cnt_write_enable)
      count_q <= wb;
    else if (tick && csr_q.wd_enable && run_cnt)
      count_q <= count_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // Overflow to chip reset
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (blk_rst)
      ovf_q <= 1'b0;
    else
      ovf_q <= wrap && !(wr_ok && sel_cnt
                         && csr_q.cnt_write_enable);
  end

  // Trigger at ovf_q, so the reset rises two cycles after wrap
  wdr_reset_stretch #(
    .CYCLES   (RST_CYCLES)
  ) u_stretch (
    .clock    (clock),
    .rst      (rst),
    .trigger  (ovf_q),
    .active_q (chip_reset_q)
  );

endmodule // wdr_watchdog
`default_nettype wire

// *** rtl/wdr_pkg.sv ***
// Package for the watchdog reset timer: register map, field layout,
// reset values, timing constants and shared types.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package wdr_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Avalon-MM bus)
  // ----------------------------------------------------------------
  localparam int unsigned WDR_ADDR_W        = 4;
  localparam logic [3:0]  WDR_OFS_CTRL_STAT = 4'h0;
  localparam logic [3:0]  WDR_OFS_COUNT     = 4'h4;
  localparam logic [3:0]  WDR_OFS_CLKSEL    = 4'h8;

  // ----------------------------------------------------------------
  // Control/status field positions
  // ----------------------------------------------------------------
  localparam int unsigned WDR_CNT_WEN_INH  = 7;
  localparam int unsigned WDR_CNT_WEN      = 6;
  localparam int unsigned WDR_REG_WEN_INH  = 5;
  localparam int unsigned WDR_REG_WEN      = 4;
  localparam int unsigned WDR_ON_INH       = 3;
  localparam int unsigned WDR_ENABLE       = 2;
  localparam int unsigned WDR_FLAG_INH     = 1;
  localparam int unsigned WDR_FLAG         = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  WDR_COUNT_RST    = 8'h00;
  localparam logic [7:0]  WDR_COUNT_MAX    = 8'hFF;
  localparam logic [2:0]  WDR_CLKSEL_RST   = 3'h7;
  localparam logic [4:0]  WDR_CLKSEL_PAD   = 5'h1F;
  localparam logic [31:0] WDR_RDATA_ZERO   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned WDR_PRESC_W      = 13;
  localparam int unsigned WDR_TAP_BASE     = 6;
  localparam int unsigned WDR_RST_OSC_CYC  = 512;
  localparam int unsigned WDR_OSC_PER_SYS  = 2;
  localparam int unsigned WDR_RST_SYS_CYC  =
    (WDR_RST_OSC_CYC + WDR_OSC_PER_SYS - 1) / WDR_OSC_PER_SYS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    WDR_PM_ACTIVE,
    WDR_PM_SLEEP,
    WDR_PM_WATCH,
    WDR_PM_SUBACTIVE,
    WDR_PM_SUBSLEEP,
    WDR_PM_STANDBY
  } wdr_pmode_t;

  typedef struct packed {
    logic cnt_write_enable;
    logic reg_write_enable;
    logic wd_enable;
    logic overflow_reset_flag;
  } wdr_csr_t;

  localparam wdr_csr_t WDR_CSR_RST = '{default: 1'b0};

endpackage

// *** rtl/wdr_prescaler.sv ***
// Free-running system clock prescaler with eight selectable taps.
// Assumes a synchronous active-high reset on the same clock.
`timescale 1ns/100ps
`default_nettype none
module wdr_prescaler
  import wdr_pkg::*;
#(
  parameter int unsigned TAPS = 8
)(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output var  logic       tick_q
);

  logic [WDR_PRESC_W-1:0] div_q;
  logic [TAPS-1:0]        tap;

  // ----------------------------------------------------------------
  // Divider chain; halted in low-power modes that stop the counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      div_q <= '0;
    else if (run)
      div_q <= div_q + 1'b1;
  end

  // Tap i fires once every 2^(6+i) clocks
  for (genvar i = 0; i < TAPS; i++)
  begin : g_tap
    assign tap[i] = &div_q[WDR_TAP_BASE+i-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      tick_q <= 1'b0;
    else
      tick_q <= run & tap[sel];
  end

endmodule // wdr_prescaler
`default_nettype wire

// *** rtl/wdr_reset_stretch.sv ***
// Stretches a one-cycle overflow event into the chip-wide reset pulse.
// Assumes the trigger is a one-cycle pulse on the same clock.
`timescale 1ns/100ps
`default_nettype none
module wdr_reset_stretch
  import wdr_pkg::*;
#(
  parameter int unsigned CYCLES = WDR_RST_SYS_CYC
)(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic trigger,
  output var  logic active_q
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;

  // ----------------------------------------------------------------
  // Pulse length counter; the pulse must not reset itself
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      active_q <= 1'b0;
      cnt_q    <= '0;
    end
    else if (trigger && !active_q)
    begin
      active_q <= 1'b1;
      cnt_q    <= '0;
    end
    else if (active_q)
    begin
      if (cnt_q == LAST)
        active_q <= 1'b0;
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule // wdr_reset_stretch
`default_nettype wire

// *** dv/wdr_watchdog_properties.sv ***
// Concurrent checks on the watchdog bus answers and overflow reset.
// Assumes it is bound to wdr_watchdog and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module wdr_watchdog_chk
  import wdr_pkg::*;
#(
  parameter int unsigned RST_CYCLES = WDR_RST_SYS_CYC
)(
  input wire logic                  clock,
  input wire logic                  rst,
  input wire wdr_pmode_t            power_mode,
  input wire logic [WDR_ADDR_W-1:0] address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [31:0]           writedata,
  input wire logic [3:0]            byteenable,
  input wire logic [31:0]           readdata,
  input wire logic                  waitrequest,
  input wire logic                  chip_reset_q,
  input wire logic                  wd_enable_q
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [15:0] hi_q;
  logic        csr_wr;
  assign csr_wr = write && !waitrequest && address == WDR_OFS_CTRL_STAT;
  // Counts cycles of the reset pulse seen so far
  always_ff @(posedge clock)
  begin
    if (rst || !chip_reset_q)
      hi_q <= '0;
    else
      hi_q <= hi_q + 16'h0001;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req_wait;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_wait_one: assert property (s_req_wait |=> s_answer)
    else $error("bus answer not one cycle after request");
  a_idle_wait: assert property (!read && !write |=> waitrequest)
    else $error("waitrequest low without a request");
  a_inh_read_one: assert property (!waitrequest && read &&
    address == WDR_OFS_CTRL_STAT |->
    &{readdata[7], readdata[5], readdata[3], readdata[1]})
    else $error("inhibit bit read as zero");
  a_clksel_pad: assert property (!waitrequest && read &&
    address == WDR_OFS_CLKSEL |-> readdata[7:3] == WDR_CLKSEL_PAD)
    else $error("clock select upper bits not one");
  a_upper_zero: assert property (!waitrequest && read |->
    readdata[31:8] == '0)
    else $error("read data above byte not zero");
  a_pulse_len: assert property ($fell(chip_reset_q) |->
    hi_q == 16'(RST_CYCLES))
    else $error("overflow reset pulse length wrong");
  a_pulse_max: assert property (chip_reset_q |->
    hi_q < 16'(RST_CYCLES))
    else $error("overflow reset pulse too long");
  a_reset_clears_on: assert property (chip_reset_q ##1 chip_reset_q
    |-> !wd_enable_q)
    else $error("internal reset left watchdog on");
  a_enable_guard: assert property ($changed(wd_enable_q) |->
    $past(csr_wr) || $past(chip_reset_q))
    else $error("watchdog on bit changed without a write");
endmodule // wdr_watchdog_chk
bind wdr_watchdog wdr_watchdog_chk #(.RST_CYCLES(RST_CYCLES)) chk_u (
  .clock(clock), .rst(rst), .power_mode(power_mode), .address(address),
  .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .chip_reset_q(chip_reset_q),
  .wd_enable_q(wd_enable_q));
`default_nettype wire

// *** dv/wdr_cpu_model.sv ***
// Processor side model: an Avalon-MM master with byte read and write.
// Assumes the bench calls its tasks only after reset is released.
`timescale 1ns/100ps
`default_nettype none
module wdr_cpu_model
  import wdr_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic [31:0]           readdata,
  input  wire logic                  waitrequest,
  output var  logic [WDR_ADDR_W-1:0] address,
  output var  logic                  read,
  output var  logic                  write,
  output var  logic [31:0]           writedata,
  output var  logic [3:0]            byteenable
);
  initial
  begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'h1;
  end
  // Request held until the edge that sees waitrequest low
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    d = readdata[7:0];
    read <= 1'b0;
  endtask
endmodule // wdr_cpu_model
`default_nettype wire

// *** dv/wdr_watchdog_test.sv ***
// Self-checking bench for the watchdog reset timer.
// Assumes a short reset pulse parameter so overflows finish quickly.
`timescale 1ns/100ps
`default_nettype none
module wdr_watchdog_test;
  import wdr_pkg::*;
  localparam int unsigned RC = 4;
  logic        clock = 1'b0;
  logic        rst;
  wdr_pmode_t  power_mode;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        chip_reset_q;
  logic        wd_enable_q;
  logic [7:0]  va;
  logic [7:0]  vb;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #25 clock = ~clock;
  wdr_watchdog #(.RST_CYCLES(RC)) dut_u (
    .clock(clock), .rst(rst), .power_mode(power_mode),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .chip_reset_q(chip_reset_q), .wd_enable_q(wd_enable_q));
  wdr_cpu_model cpu_u (
    .clock(clock), .readdata(readdata), .waitrequest(waitrequest),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] s,
                     input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e,
                    input string nm);
    logic [7:0] v;
    cpu_u.rd(a, v);
    chk(nm, v, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Whole run needs about 900 cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    power_mode = WDR_PM_ACTIVE;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    rc(WDR_OFS_CTRL_STAT, 8'hAA, "csr reset");
    rc(WDR_OFS_COUNT, 8'h00, "count reset");
    rc(WDR_OFS_CLKSEL, 8'hFF, "clksel reset");
    rc(4'hC, 8'h00, "unmapped");
    cpu_u.wr(WDR_OFS_COUNT, 8'h55);
    rc(WDR_OFS_COUNT, 8'h00, "count locked");
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'hC0);
    rc(WDR_OFS_CTRL_STAT, 8'hAA, "cnt wen inhibited");
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'h40);
    rc(WDR_OFS_CTRL_STAT, 8'hEA, "cnt wen set");
    // Enable gate opens in the same write that tries to turn on
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'h96);
    @(posedge clock);
    chk("on before gate", {7'h00, wd_enable_q}, 8'h00);
    rc(WDR_OFS_CTRL_STAT, 8'hFA, "reg wen set");
    for (int s = 7; s >= 0; s--)
    begin
      cpu_u.wr(WDR_OFS_CLKSEL, 8'(s));
      rc(WDR_OFS_CLKSEL, {5'h1F, 3'(s)}, "clksel code");
    end
    cpu_u.wr(WDR_OFS_COUNT, 8'h10);
    rc(WDR_OFS_COUNT, 8'h10, "count preload");
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'hA6);
    @(posedge clock);
    chk("on set", {7'h00, wd_enable_q}, 8'h01);
    repeat (200) @(posedge clock);
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'hA2);
    @(posedge clock);
    chk("on cleared", {7'h00, wd_enable_q}, 8'h00);
    cpu_u.rd(WDR_OFS_COUNT, va);
    chk("count advanced", {7'h00, va > 8'h12}, 8'h01);
    repeat (200) @(posedge clock);
    rc(WDR_OFS_COUNT, va, "count stopped");
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'hA6);
    power_mode <= WDR_PM_WATCH;
    cpu_u.rd(WDR_OFS_COUNT, vb);
    repeat (200) @(posedge clock);
    rc(WDR_OFS_COUNT, vb, "count halted");
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'hA2);
    @(posedge clock);
    chk("csr held", {7'h00, wd_enable_q}, 8'h01);
    power_mode <= WDR_PM_SLEEP;
    cpu_u.wr(WDR_OFS_CLKSEL, 8'h07);
    rc(WDR_OFS_CLKSEL, 8'hF8, "clksel held");
    power_mode <= WDR_PM_ACTIVE;
    cpu_u.wr(WDR_OFS_COUNT, 8'hFF);
    for (int i = 0; i < 300 && chip_reset_q !== 1'b1; i++)
      @(posedge clock);
    chk("chip reset", {7'h00, chip_reset_q}, 8'h01);
    for (int i = 0; i < 40 && chip_reset_q !== 1'b0; i++)
      @(posedge clock);
    chk("on after reset", {7'h00, wd_enable_q}, 8'h00);
    rc(WDR_OFS_CTRL_STAT, 8'hAB, "flag kept");
    rc(WDR_OFS_COUNT, 8'h00, "count cleared");
    rc(WDR_OFS_CLKSEL, 8'hFF, "clksel cleared");
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'h1B);
    rc(WDR_OFS_CTRL_STAT, 8'hBB, "flag write one");
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'h18);
    rc(WDR_OFS_CTRL_STAT, 8'hBA, "flag cleared");
    cpu_u.wr(WDR_OFS_CTRL_STAT, 8'h19);
    rc(WDR_OFS_CTRL_STAT, 8'hBA, "flag not set");
    print_verdict();
  end
endmodule // wdr_watchdog_test
`default_nettype wire
